// >>> src/pnpp_pkg.sv
// constants for the parallel nvm programming port controller
// Notes on behaviour
// - chip erase: long write pulse, no busy
// - command load: action 10, byte low, pulse
// - action 00 loads address byte by selector
// - wait for ready high before next byte
// - high-byte write with selector high
// - reload address high only on new page
// - skip writing erased all-ones value
// - eeprom write: command 0001 0001, low byte
// - fuse write: fuse pulse width, no busy
// - reserved fuse/protection data bits driven one
package pnpp_pkg;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam real CLK_NS = 5.0;
  localparam real T_SETUP_NS = 67.0;
  localparam real T_XHIGH_NS = 67.0;
  localparam real T_HOLD_NS = 67.0;
  localparam real T_WLOW_NS = 67.0;
  localparam real T_BSHOLD_NS = 67.0;
  localparam real T_WHRL_NS = 20.0;
  localparam real T_OLDV_NS = 20.0;
  localparam real T_OHDZ_NS = 20.0;
  localparam real T_ERASE_MS = 5.0;
  localparam real T_FUSE_MS = 1.0;
  localparam int SYNC_CYC = 2;
  localparam int SETUP_CYC = int'($ceil(T_SETUP_NS / CLK_NS));
  localparam int XHIGH_CYC = int'($ceil(T_XHIGH_NS / CLK_NS));
  localparam int HOLD_CYC = int'($ceil(T_HOLD_NS / CLK_NS));
  localparam int WLOW_CYC = int'($ceil(T_WLOW_NS / CLK_NS));
  localparam int BSHOLD_CYC = int'($ceil(T_BSHOLD_NS / CLK_NS));
  localparam int WHRL_CYC = int'($ceil(T_WHRL_NS / CLK_NS)) + SYNC_CYC;
  localparam int OLDV_CYC = int'($ceil(T_OLDV_NS / CLK_NS)) + SYNC_CYC;
  localparam int OHDZ_CYC = int'($ceil(T_OHDZ_NS / CLK_NS));
  localparam int ERASE_CYC = int'($ceil(T_ERASE_MS * 1.0e6 / CLK_NS));
  localparam int FUSE_CYC = int'($ceil(T_FUSE_MS * 1.0e6 / CLK_NS));
  localparam int CNT_W = 22;

  // ----------------------------------------
  // device commands and pin codes
  // ----------------------------------------
  localparam logic [7:0] CMD_ERASE = 8'h80;
  localparam logic [7:0] CMD_WR_FUSE = 8'h40;
  localparam logic [7:0] CMD_WR_LOCK = 8'h20;
  localparam logic [7:0] CMD_WR_FLASH = 8'h10;
  localparam logic [7:0] CMD_WR_EE = 8'h11;
  localparam logic [7:0] CMD_RD_SIG = 8'h08;
  localparam logic [7:0] CMD_RD_FUSE = 8'h04;
  localparam logic [7:0] CMD_RD_FLASH = 8'h02;
  localparam logic [7:0] CMD_RD_EE = 8'h03;
  localparam logic [1:0] ACT_ADDR = 2'h0;
  localparam logic [1:0] ACT_DATA = 2'h1;
  localparam logic [1:0] ACT_CMD = 2'h2;
  localparam logic [1:0] ACT_IDLE = 2'h3;
  localparam logic [7:0] FUSE_RSVD = 8'hde;
  localparam logic [7:0] LOCK_RSVD = 8'hf9;
  localparam logic [7:0] ERASED = 8'hff;

  // ----------------------------------------
  // software registers
  // ----------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam int CTRL_OP_LSB = 8;
  localparam int CTRL_BS_BIT = 11;
  localparam int ST_BUSY = 0;
  localparam int ST_RDY = 1;
  localparam int ST_REFUSED = 2;
  localparam int ST_SKIPPED = 3;
  localparam int ST_RDATA_LSB = 8;
  localparam logic [2:0] OP_LOAD_CMD = 3'h0;
  localparam logic [2:0] OP_LOAD_ADDR = 3'h1;
  localparam logic [2:0] OP_LOAD_DATA = 3'h2;
  localparam logic [2:0] OP_WRITE = 3'h3;
  localparam logic [2:0] OP_READ = 3'h4;

endpackage

// >>> src/pnpp_host.sv
// programmer that drives the parallel nvm programming pins
//
// Decided for this implementation: the Wishbone slave port and the register addresses.
`timescale 1ns/10ps
module pnpp_host #(
  parameter int ERASE_CYC = pnpp_pkg::ERASE_CYC,
  parameter int FUSE_CYC = pnpp_pkg::FUSE_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // device pins
  output logic load_clock_pin_o,
  output logic action_sel_hi_o,
  output logic action_sel_lo_o,
  output logic byte_selector_o,
  output logic wr_n_o,
  output logic oe_n_o,
  output logic [7:0] data_o,
  output logic data_oe_n_o,
  input wire logic [7:0] data_i,
  input wire logic ready_busy_out_i
);

  typedef enum logic [2:0] {S_IDLE, S_SETUP, S_PULSE, S_GAP, S_POLL, S_HOLD} pnpp_state_t;

  localparam logic [pnpp_pkg::CNT_W-1:0] C_SETUP = pnpp_pkg::CNT_W'(pnpp_pkg::SETUP_CYC - 1);
  localparam logic [pnpp_pkg::CNT_W-1:0] C_XHIGH = pnpp_pkg::CNT_W'(pnpp_pkg::XHIGH_CYC - 1);
  localparam logic [pnpp_pkg::CNT_W-1:0] C_HOLD = pnpp_pkg::CNT_W'(pnpp_pkg::HOLD_CYC - 1);
  localparam logic [pnpp_pkg::CNT_W-1:0] C_WLOW = pnpp_pkg::CNT_W'(pnpp_pkg::WLOW_CYC - 1);
  localparam logic [pnpp_pkg::CNT_W-1:0] C_BSHOLD = pnpp_pkg::CNT_W'(pnpp_pkg::BSHOLD_CYC - 1);
  localparam logic [pnpp_pkg::CNT_W-1:0] C_WHRL = pnpp_pkg::CNT_W'(pnpp_pkg::WHRL_CYC - 1);
  localparam logic [pnpp_pkg::CNT_W-1:0] C_OLDV = pnpp_pkg::CNT_W'(pnpp_pkg::OLDV_CYC - 1);
  localparam logic [pnpp_pkg::CNT_W-1:0] C_OHDZ = pnpp_pkg::CNT_W'(pnpp_pkg::OHDZ_CYC - 1);
  localparam logic [pnpp_pkg::CNT_W-1:0] C_ERASE = pnpp_pkg::CNT_W'(ERASE_CYC - 1);
  localparam logic [pnpp_pkg::CNT_W-1:0] C_FUSE = pnpp_pkg::CNT_W'(FUSE_CYC - 1);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic rdy_m_q;
  logic rdy_s_q;
  logic [7:0] din_m_q;
  logic [7:0] din_s_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdy_m_q <= 1'b1;
      rdy_s_q <= 1'b1;
      din_m_q <= 8'h00;
      din_s_q <= 8'h00;
    end else if (ce_i) begin
      rdy_m_q <= ready_busy_out_i;
      rdy_s_q <= rdy_m_q;
      din_m_q <= data_i;
      din_s_q <= din_m_q;
    end
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  pnpp_state_t st_q, st_d;
  logic [pnpp_pkg::CNT_W-1:0] cnt_q, cnt_d;
  logic [2:0] op_q, op_d;
  logic [1:0] act_q, act_d;
  logic bs_q, bs_d;
  logic xclk_q, xclk_d;
  logic wr_n_q, wr_n_d;
  logic oe_n_q, oe_n_d;
  logic [7:0] dout_q, dout_d;
  logic doe_n_q, doe_n_d;
  logic [7:0] cmd_q, cmd_d;
  logic cmd_ok_q, cmd_ok_d;
  logic [7:0] ahi_q, ahi_d;
  logic ahi_ok_q, ahi_ok_d;
  logic [7:0] dat_q, dat_d;
  logic [7:0] rdata_q, rdata_d;
  logic timed_q, timed_d;
  logic skip_q, skip_d;
  // software request, held by the bus group
  logic start_q;
  logic [2:0] req_op_q;
  logic req_bs_q;
  logic [7:0] req_byte_q;

  always_comb begin
    st_d = st_q;
    cnt_d = (cnt_q != '0) ? cnt_q - 1'b1 : cnt_q;
    op_d = op_q;
    act_d = act_q;
    bs_d = bs_q;
    xclk_d = xclk_q;
    wr_n_d = wr_n_q;
    oe_n_d = oe_n_q;
    dout_d = dout_q;
    doe_n_d = doe_n_q;
    cmd_d = cmd_q;
    cmd_ok_d = cmd_ok_q;
    ahi_d = ahi_q;
    ahi_ok_d = ahi_ok_q;
    dat_d = dat_q;
    rdata_d = rdata_q;
    timed_d = timed_q;
    skip_d = 1'b0;
    case (st_q)
      S_IDLE: begin
        if (start_q) begin
          op_d = req_op_q;
          bs_d = req_bs_q;
          cnt_d = C_SETUP;
          st_d = S_SETUP;
          case (req_op_q)
            pnpp_pkg::OP_LOAD_CMD: begin
              // an unchanged command stays latched in the device
              if (cmd_ok_q && req_byte_q == cmd_q) begin
                skip_d = 1'b1;
                st_d = S_IDLE;
              end else begin
                act_d = pnpp_pkg::ACT_CMD;
                bs_d = 1'b0;
                dout_d = req_byte_q;
                cmd_d = req_byte_q;
                cmd_ok_d = 1'b1;
                // a new command forgets the cached page
                ahi_ok_d = 1'b0;
              end
            end
            pnpp_pkg::OP_LOAD_ADDR: begin
              if (req_bs_q && ahi_ok_q && req_byte_q == ahi_q) begin
                skip_d = 1'b1;
                st_d = S_IDLE;
              end else begin
                act_d = pnpp_pkg::ACT_ADDR;
                dout_d = req_byte_q;
                if (req_bs_q) begin
                  ahi_d = req_byte_q;
                  ahi_ok_d = 1'b1;
                end
              end
            end
            pnpp_pkg::OP_LOAD_DATA: begin
              act_d = pnpp_pkg::ACT_DATA;
              if (cmd_q == pnpp_pkg::CMD_WR_FUSE) begin
                dout_d = req_byte_q | pnpp_pkg::FUSE_RSVD;
              end else if (cmd_q == pnpp_pkg::CMD_WR_LOCK) begin
                dout_d = req_byte_q | pnpp_pkg::LOCK_RSVD;
              end else begin
                dout_d = req_byte_q;
              end
              dat_d = dout_d;
            end
            pnpp_pkg::OP_WRITE: begin
              act_d = pnpp_pkg::ACT_IDLE;
              if ((cmd_q == pnpp_pkg::CMD_WR_FLASH || cmd_q == pnpp_pkg::CMD_WR_EE)
                  && dat_q == pnpp_pkg::ERASED) begin
                skip_d = 1'b1;
                st_d = S_IDLE;
              end
            end
            default: begin
              // read: release the data bus before oe falls
              act_d = pnpp_pkg::ACT_IDLE;
              doe_n_d = 1'b1;
            end
          endcase
        end
      end
      S_SETUP: begin
        if (cnt_q == '0) begin
          st_d = S_PULSE;
          case (op_q)
            pnpp_pkg::OP_WRITE: begin
              wr_n_d = 1'b0;
              timed_d = 1'b1;
              if (cmd_q == pnpp_pkg::CMD_ERASE) begin
                cnt_d = C_ERASE;
              end else if (cmd_q == pnpp_pkg::CMD_WR_FUSE) begin
                cnt_d = C_FUSE;
              end else begin
                cnt_d = C_WLOW;
                timed_d = 1'b0;
              end
            end
            pnpp_pkg::OP_READ: begin
              // flash, eeprom, fuse status or id byte per loaded command
              oe_n_d = 1'b0;
              cnt_d = C_OLDV;
            end
            default: begin
              xclk_d = 1'b1;
              cnt_d = C_XHIGH;
            end
          endcase
        end
      end
      S_PULSE: begin
        if (cnt_q == '0) begin
          st_d = S_HOLD;
          cnt_d = C_HOLD;
          case (op_q)
            pnpp_pkg::OP_WRITE: begin
              wr_n_d = 1'b1;
              // erase and fuse writes show no busy on the pin
              if (!timed_q) begin
                st_d = S_GAP;
                cnt_d = C_WHRL;
              end
            end
            pnpp_pkg::OP_READ: begin
              rdata_d = din_s_q;
              oe_n_d = 1'b1;
              cnt_d = C_OHDZ;
            end
            default: begin
              xclk_d = 1'b0;
            end
          endcase
        end
      end
      S_GAP: begin
        if (cnt_q == '0) begin
          st_d = S_POLL;
        end
      end
      S_POLL: begin
        // byte selector held until ready comes back
        if (rdy_s_q) begin
          st_d = S_HOLD;
          cnt_d = C_BSHOLD;
        end
      end
      S_HOLD: begin
        if (cnt_q == '0) begin
          act_d = pnpp_pkg::ACT_IDLE;
          doe_n_d = 1'b0;
          st_d = S_IDLE;
        end
      end
      default: begin
        st_d = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= S_IDLE;
      cnt_q <= '0;
      op_q <= pnpp_pkg::OP_LOAD_CMD;
      act_q <= pnpp_pkg::ACT_IDLE;
      bs_q <= 1'b0;
      xclk_q <= 1'b0;
      wr_n_q <= 1'b1;
      oe_n_q <= 1'b1;
      dout_q <= 8'h00;
      doe_n_q <= 1'b0;
      cmd_q <= 8'h00;
      cmd_ok_q <= 1'b0;
      ahi_q <= 8'h00;
      ahi_ok_q <= 1'b0;
      dat_q <= 8'h00;
      rdata_q <= 8'h00;
      timed_q <= 1'b0;
      skip_q <= 1'b0;
    end else if (ce_i) begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      op_q <= op_d;
      act_q <= act_d;
      bs_q <= bs_d;
      xclk_q <= xclk_d;
      wr_n_q <= wr_n_d;
      oe_n_q <= oe_n_d;
      dout_q <= dout_d;
      doe_n_q <= doe_n_d;
      cmd_q <= cmd_d;
      cmd_ok_q <= cmd_ok_d;
      ahi_q <= ahi_d;
      ahi_ok_q <= ahi_ok_d;
      dat_q <= dat_d;
      rdata_q <= rdata_d;
      timed_q <= timed_d;
      skip_q <= skip_d;
    end
  end

  // ----------------------------------------
  // wishbone registers
  // ----------------------------------------
  localparam int CTRL_OP_HI = pnpp_pkg::CTRL_OP_LSB + 2;
  localparam int RDATA_HI = pnpp_pkg::ST_RDATA_LSB + 7;

  logic ack_q, ack_d;
  logic [31:0] rd_q, rd_d;
  logic start_d;
  logic [2:0] req_op_d;
  logic req_bs_d;
  logic [7:0] req_byte_d;
  logic refused_q, refused_d;
  logic skipped_q, skipped_d;
  logic busy;
  logic req;

  assign busy = (st_q != S_IDLE) || start_q;
  assign req = wb_cyc_i && wb_stb_i && !ack_q;

  always_comb begin
    ack_d = req;
    rd_d = rd_q;
    start_d = 1'b0;
    req_op_d = req_op_q;
    req_bs_d = req_bs_q;
    req_byte_d = req_byte_q;
    refused_d = refused_q;
    skipped_d = skipped_q;
    if (req && !wb_we_i) begin
      rd_d = 32'h0000_0000;
      if (wb_adr_i == pnpp_pkg::REG_CTRL) begin
        rd_d[7:0] = req_byte_q;
        rd_d[CTRL_OP_HI:pnpp_pkg::CTRL_OP_LSB] = req_op_q;
        rd_d[pnpp_pkg::CTRL_BS_BIT] = req_bs_q;
      end else if (wb_adr_i == pnpp_pkg::REG_STATUS) begin
        rd_d[pnpp_pkg::ST_BUSY] = busy;
        rd_d[pnpp_pkg::ST_RDY] = rdy_s_q;
        rd_d[pnpp_pkg::ST_REFUSED] = refused_q;
        rd_d[pnpp_pkg::ST_SKIPPED] = skipped_q;
        rd_d[RDATA_HI:pnpp_pkg::ST_RDATA_LSB] = rdata_q;
      end
    end
    if (req && wb_we_i && wb_adr_i == pnpp_pkg::REG_STATUS && wb_sel_i[0]) begin
      if (wb_dat_i[pnpp_pkg::ST_REFUSED]) begin
        refused_d = 1'b0;
      end
      if (wb_dat_i[pnpp_pkg::ST_SKIPPED]) begin
        skipped_d = 1'b0;
      end
    end
    if (req && wb_we_i && wb_adr_i == pnpp_pkg::REG_CTRL && wb_sel_i[1:0] == 2'h3) begin
      if (busy || wb_dat_i[CTRL_OP_HI:pnpp_pkg::CTRL_OP_LSB] > pnpp_pkg::OP_READ) begin
        refused_d = 1'b1;
      end else begin
        start_d = 1'b1;
        req_byte_d = wb_dat_i[7:0];
        req_op_d = wb_dat_i[CTRL_OP_HI:pnpp_pkg::CTRL_OP_LSB];
        req_bs_d = wb_dat_i[pnpp_pkg::CTRL_BS_BIT];
      end
    end
    // a new event wins over a clear in the same cycle
    if (skip_q) begin
      skipped_d = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      rd_q <= 32'h0000_0000;
      start_q <= 1'b0;
      req_op_q <= pnpp_pkg::OP_LOAD_CMD;
      req_bs_q <= 1'b0;
      req_byte_q <= 8'h00;
      refused_q <= 1'b0;
      skipped_q <= 1'b0;
    end else if (ce_i) begin
      ack_q <= ack_d;
      rd_q <= rd_d;
      start_q <= start_d;
      req_op_q <= req_op_d;
      req_bs_q <= req_bs_d;
      req_byte_q <= req_byte_d;
      refused_q <= refused_d;
      skipped_q <= skipped_d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rd_q;
  assign load_clock_pin_o = xclk_q;
  assign action_sel_hi_o = act_q[1];
  assign action_sel_lo_o = act_q[0];
  assign byte_selector_o = bs_q;
  assign wr_n_o = wr_n_q;
  assign oe_n_o = oe_n_q;
  assign data_o = dout_q;
  assign data_oe_n_o = doe_n_q;

endmodule

// >>> tb/pnpp_chk.sv
// concurrent checks on the programming port controller pins
`timescale 1ns/10ps
module pnpp_chk #(
  parameter int ERASE_CYC = 50,
  parameter int FUSE_CYC = 20
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // wishbone
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // device pins
  input wire logic load_clock_pin_o,
  input wire logic action_sel_hi_o,
  input wire logic action_sel_lo_o,
  input wire logic byte_selector_o,
  input wire logic wr_n_o,
  input wire logic oe_n_o,
  input wire logic [7:0] data_o,
  input wire logic data_oe_n_o,
  input wire logic ready_busy_out_i
);
  logic [7:0] cmd_q, cmd_d;
  logic [21:0] low_q, low_d, want;
  logic [1:0] act;
  assign act = {action_sel_hi_o, action_sel_lo_o};
  assign want = (cmd_q == 8'h80) ? 22'(ERASE_CYC) : (cmd_q == 8'h40) ? 22'(FUSE_CYC) : 22'h00000e;

  // last command and strobe low time
  always_comb begin
    cmd_d = (load_clock_pin_o && act == 2'h2) ? data_o : cmd_q;
    low_d = wr_n_o ? 22'h000000 : low_q + 22'h000001;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmd_q <= 8'h00;
      low_q <= 22'h000000;
    end else begin
      cmd_q <= cmd_d;
      low_q <= low_d;
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  chk_wr_width: assert property ($rose(wr_n_o) |-> low_q == want)
    else $error("write strobe low time wrong");
  chk_load_pulse: assert property ($rose(load_clock_pin_o) |->
    load_clock_pin_o[*8] ##1 load_clock_pin_o[*6] ##1 !load_clock_pin_o)
    else $error("load clock pulse width wrong");
  chk_load_stable: assert property (load_clock_pin_o |->
    $stable({act, byte_selector_o, data_o}) && !data_oe_n_o && act != 2'h3 && wr_n_o && oe_n_o)
    else $error("pins moved during load pulse");
  chk_wr_idle_act: assert property (!wr_n_o |->
    act == 2'h3 && !load_clock_pin_o && oe_n_o && $stable(byte_selector_o))
    else $error("write strobe with active selector");
  chk_busy_wait: assert property (!ready_busy_out_i |=>
    wr_n_o && oe_n_o && !$rose(load_clock_pin_o))
    else $error("activity while device busy");
  chk_rsvd_ones: assert property ($rose(load_clock_pin_o) && act == 2'h1 |->
    (cmd_q != 8'h40 || (data_o & 8'hde) == 8'hde) &&
    (cmd_q != 8'h20 || (data_o & 8'hf9) == 8'hf9))
    else $error("reserved data bit driven zero");
  chk_oe_window: assert property ($fell(oe_n_o) |-> !oe_n_o[*6] ##1 oe_n_o)
    else $error("read enable window wrong");
  chk_bus_release: assert property (!oe_n_o |-> data_oe_n_o)
    else $error("host drives bus during read");
  chk_redrive_gap: assert property ($rose(oe_n_o) |-> data_oe_n_o[*4] ##[1:2] !data_oe_n_o)
    else $error("bus redriven too early or never");
  chk_fuse_rd_bs: assert property (!oe_n_o && cmd_q == 8'h04 |-> byte_selector_o)
    else $error("status read with low selector");
  chk_ee_wr_bs: assert property (!wr_n_o && cmd_q == 8'h11 |-> !byte_selector_o)
    else $error("eeprom write with high selector");
  chk_ack_once: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=>
    wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack not a single pulse");
endmodule

bind pnpp_host pnpp_chk #(.ERASE_CYC(ERASE_CYC), .FUSE_CYC(FUSE_CYC)) u_chk (.clk_i, .rst_i,
  .ce_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .load_clock_pin_o, .action_sel_hi_o, .action_sel_lo_o,
  .byte_selector_o, .wr_n_o, .oe_n_o, .data_o, .data_oe_n_o, .ready_busy_out_i);

// >>> tb/pnpp_dev_model.sv
// behavioural model of the device behind the programming port
`timescale 1ns/10ps
module pnpp_dev_model #(
  parameter logic [23:0] SIG = 24'h695a3c // arbitrary identity bytes
) (
  // clock and busy length
  input wire logic clk_i,
  input wire logic [7:0] busy_len_i,
  // port pins
  input wire logic load_clock_i,
  input wire logic act_hi_i,
  input wire logic act_lo_i,
  input wire logic bs_i,
  input wire logic wr_n_i,
  input wire logic oe_n_i,
  input wire logic [7:0] dq_i,
  output logic [7:0] dq_o,
  output logic dq_drive_n_o,
  output logic ready_o
);
  logic [7:0] cmd, ahi, alo, dlo, dhi, fuse, lock;
  logic [7:0] busy_cnt = 8'h00;
  logic wr_n_last = 1'b1;
  logic [7:0] fl_lo [1024];
  logic [7:0] fl_hi [1024];
  logic [7:0] ee [128];
  logic [9:0] idx;
  assign idx = {ahi[1:0], alo};
  assign ready_o = (busy_cnt == 8'h00);
  assign dq_drive_n_o = oe_n_i;

  task automatic wipe();
    for (int i = 0; i < 1024; i++) begin
      fl_lo[i] = 8'hff;
      fl_hi[i] = 8'hff;
      ee[i % 128] = 8'hff;
    end
  endtask

  initial begin
    {cmd, ahi, alo, dlo, dhi} = '0;
    fuse = 8'hff;
    lock = 8'hff;
    wipe();
  end

  always @(posedge load_clock_i) begin
    case ({act_hi_i, act_lo_i})
      2'h0: begin
        if (bs_i) ahi = dq_i;
        else alo = dq_i;
      end
      2'h1: begin
        if (bs_i) dhi = dq_i;
        else dlo = dq_i;
      end
      2'h2: cmd = dq_i;
      default: ;
    endcase
  end

  // command and address stay until reloaded
  always @(posedge wr_n_i) begin
    case (cmd)
      8'h80: begin
        wipe();
        lock = 8'hff;
      end
      8'h40: fuse = dlo;
      8'h20: lock = lock & dlo;
      8'h10: begin
        if (bs_i) fl_hi[idx] = dhi;
        else fl_lo[idx] = dlo;
      end
      8'h11: begin
        ee[alo[6:0]] = dlo;
      end
      default: ;
    endcase
  end
  // busy only after flash and eeprom byte writes
  always @(posedge clk_i) begin
    wr_n_last <= wr_n_i;
    if (wr_n_i && !wr_n_last && (cmd == 8'h10 || cmd == 8'h11)) busy_cnt <= busy_len_i;
    else if (busy_cnt != 8'h00) busy_cnt <= busy_cnt - 8'h01;
  end

  always_comb begin
    case (cmd)
      8'h02: dq_o = bs_i ? fl_hi[idx] : fl_lo[idx];
      8'h03: dq_o = ee[alo[6:0]];
      8'h04: dq_o = {lock[1], lock[2], fuse[5], 4'hf, fuse[0]};
      8'h08: dq_o = SIG[8 * alo[1:0] +: 8];
      default: dq_o = 8'h00;
    endcase
  end
endmodule

// >>> tb/tb.sv
// self-checking bench for the programming port controller
`timescale 1ns/10ps
module tb;
  localparam logic [23:0] SIG = 24'h695a3c; // arbitrary identity bytes
  typedef struct packed {
    logic [7:0] wcmd;
    logic [7:0] rcmd;
    logic [7:0] ahi;
    logic [7:0] alo;
    logic [7:0] dat;
    logic [7:0] exp;
    logic wbs;
    logic rbs;
  } pnpp_row_t;
  logic clk_i, rst_i, ce_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, dev_drive_n;
  logic [7:0] wb_adr_i, data_o, data_i, busy_len, dev_dq;
  logic [7:0] bus_last = 8'h00;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, v;
  logic load_clock_pin_o, action_sel_hi_o, action_sel_lo_o, byte_selector_o, wr_n_o, oe_n_o;
  logic data_oe_n_o, ready_busy_out_i;
  int num_errors = 0;
  int checks_done = 0;
  int cycles = 0;
  pnpp_row_t rows [7];
  pnpp_row_t r;

  // released bus shows a changing pattern
  assign data_i = !data_oe_n_o ? data_o : !dev_drive_n ? dev_dq : ~bus_last;
  always @(posedge clk_i) bus_last <= data_i;

  pnpp_host #(.ERASE_CYC(50), .FUSE_CYC(20)) u_dut (.clk_i, .rst_i, .ce_i, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .load_clock_pin_o, .action_sel_hi_o, .action_sel_lo_o, .byte_selector_o, .wr_n_o,
    .oe_n_o, .data_o, .data_oe_n_o, .data_i, .ready_busy_out_i);
  pnpp_dev_model #(.SIG(SIG)) u_dev (.clk_i, .busy_len_i(busy_len),
    .load_clock_i(load_clock_pin_o), .act_hi_i(action_sel_hi_o), .act_lo_i(action_sel_lo_o),
    .bs_i(byte_selector_o), .wr_n_i(wr_n_o), .oe_n_i(oe_n_o), .dq_i(data_i), .dq_o(dev_dq),
    .dq_drive_n_o(dev_drive_n), .ready_o(ready_busy_out_i));

  task automatic complete_run();
    if (num_errors == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wb_xfer(input logic we, input logic [7:0] a, input logic [31:0] d,
                         output logic [31:0] q);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1) @(posedge clk_i);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic op(input logic [2:0] code, input logic [7:0] b, input logic bs);
    logic [31:0] q;
    wb_xfer(1'b1, pnpp_pkg::REG_CTRL, {20'h00000, bs, code, b}, q);
    repeat (3) @(posedge clk_i);
    q = 32'h00000001;
    while (q[pnpp_pkg::ST_BUSY] !== 1'b0) wb_xfer(1'b0, pnpp_pkg::REG_STATUS, 32'h0, q);
  endtask

  task automatic rd_chk(input logic bs, input logic [7:0] exp);
    logic [31:0] q;
    op(pnpp_pkg::OP_READ, 8'h00, bs);
    wb_xfer(1'b0, pnpp_pkg::REG_STATUS, 32'h0, q);
    check(q[15:8], exp);
  endtask

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      num_errors++;
      complete_run();
    end
  end

  initial begin
    {rst_i, ce_i, wb_cyc_i, wb_stb_i, wb_we_i} = 5'b11000;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hf;
    wb_dat_i = 32'h0;
    busy_len = 8'h01;
    rows = '{'{8'h10, 8'h02, 8'h01, 8'h05, 8'ha5, 8'ha5, 1'b0, 1'b0},
             '{8'h10, 8'h02, 8'h02, 8'h05, 8'h3c, 8'h3c, 1'b1, 1'b1},
             '{8'h11, 8'h03, 8'h00, 8'h7f, 8'h5a, 8'h5a, 1'b0, 1'b0},
             '{8'h40, 8'h04, 8'h00, 8'h00, 8'h00, 8'hde, 1'b0, 1'b1},
             '{8'h20, 8'h04, 8'h00, 8'h00, 8'h00, 8'h1e, 1'b0, 1'b1},
             '{8'h00, 8'h08, 8'h00, 8'h00, 8'h00, SIG[7:0], 1'b0, 1'b0},
             '{8'h00, 8'h08, 8'h00, 8'h02, 8'h00, SIG[23:16], 1'b0, 1'b0}};
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    check({load_clock_pin_o, action_sel_hi_o, action_sel_lo_o, byte_selector_o, wr_n_o,
           oe_n_o, data_oe_n_o}, 32'h36);
    wb_xfer(1'b0, pnpp_pkg::REG_STATUS, 32'h0, v);
    check(v, 32'h00000002);
    wb_xfer(1'b0, 8'h40, 32'h0, v);
    check(v, 32'h0);
    foreach (rows[i]) begin
      r = rows[i];
      if (r.wcmd != 8'h00) begin
        op(pnpp_pkg::OP_LOAD_CMD, r.wcmd, 1'b0);
        if (r.wcmd == 8'h10) op(pnpp_pkg::OP_LOAD_ADDR, r.ahi, 1'b1);
        if (r.wcmd[4]) op(pnpp_pkg::OP_LOAD_ADDR, r.alo, 1'b0);
        op(pnpp_pkg::OP_LOAD_DATA, r.dat, r.wbs);
        op(pnpp_pkg::OP_WRITE, 8'h00, r.wbs);
      end
      op(pnpp_pkg::OP_LOAD_CMD, r.rcmd, 1'b0);
      if (r.rcmd == 8'h08) op(pnpp_pkg::OP_LOAD_ADDR, r.alo, 1'b0);
      rd_chk(r.rbs, r.exp);
    end
    // one command load, slow device, erased value skipped
    busy_len <= 8'h28;
    op(pnpp_pkg::OP_LOAD_CMD, 8'h10, 1'b0);
    op(pnpp_pkg::OP_LOAD_ADDR, 8'h00, 1'b1);
    for (int j = 0; j < 2; j++) begin
      op(pnpp_pkg::OP_LOAD_ADDR, 8'h10 + 8'(j), 1'b0);
      op(pnpp_pkg::OP_LOAD_DATA, 8'h60 + 8'(j), 1'b0);
      op(pnpp_pkg::OP_WRITE, 8'h00, 1'b0);
    end
    // clear skips left by earlier repeated loads
    wb_xfer(1'b1, pnpp_pkg::REG_STATUS, 32'h00000008, v);
    wb_xfer(1'b0, pnpp_pkg::REG_STATUS, 32'h0, v);
    check(v[3], 32'h0);
    op(pnpp_pkg::OP_LOAD_DATA, 8'hff, 1'b0);
    op(pnpp_pkg::OP_WRITE, 8'h00, 1'b0);
    wb_xfer(1'b0, pnpp_pkg::REG_STATUS, 32'h0, v);
    check(v[3], 32'h1);
    op(pnpp_pkg::OP_LOAD_CMD, 8'h02, 1'b0);
    for (int j = 0; j < 2; j++) begin
      op(pnpp_pkg::OP_LOAD_ADDR, 8'h10 + 8'(j), 1'b0);
      rd_chk(1'b0, 8'h60 + 8'(j));
    end
    wb_xfer(1'b1, pnpp_pkg::REG_CTRL, 32'h00000500, v);
    wb_xfer(1'b0, pnpp_pkg::REG_STATUS, 32'h0, v);
    check(v[2], 32'h1);
    // reset in mid-run clears sticky flags and caches
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb_xfer(1'b0, pnpp_pkg::REG_STATUS, 32'h0, v);
    check(v, 32'h00000002);
    // erase clears memories and protection, keeps fuses
    busy_len <= 8'h01;
    op(pnpp_pkg::OP_LOAD_CMD, 8'h80, 1'b0);
    op(pnpp_pkg::OP_WRITE, 8'h00, 1'b0);
    op(pnpp_pkg::OP_LOAD_CMD, 8'h02, 1'b0);
    rd_chk(1'b0, 8'hff);
    op(pnpp_pkg::OP_LOAD_CMD, 8'h03, 1'b0);
    op(pnpp_pkg::OP_LOAD_ADDR, 8'h7f, 1'b0);
    rd_chk(1'b0, 8'hff);
    op(pnpp_pkg::OP_LOAD_CMD, 8'h04, 1'b0);
    rd_chk(1'b1, 8'hde);
    complete_run();
  end
endmodule
